// ### gdh_pkg.sv
// Purpose: shared constants for the bus data hold block
// Assumes: byte-wide register port, 16-bit interface data bus
// Notes: hold codes follow the two-bit hold select field
package gdh_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int REG_W = 8;
    localparam logic [15:0] HOLD_AMOUNT_OFS = 16'hE60C;
    localparam logic [15:0] HOLD_STATUS_OFS = 16'hE60D;
    localparam int HOLD_FIELD_LSB = 0;
    localparam int HOLD_FIELD_W = 2;
    localparam logic [1:0] HOLD_NONE = 2'h0;
    localparam logic [1:0] HOLD_HALF = 2'h1;
    localparam logic [1:0] HOLD_ONE = 2'h2;
    localparam logic [1:0] HOLD_RSVD = 2'h3;
    localparam logic [1:0] HOLD_RESET = 2'h0;
    localparam logic [7:0] HOLD_AMOUNT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
    localparam int STAT_OE_BIT = 0;
    localparam int STAT_RDY_BIT = 1;
    localparam int STAT_STB_BIT = 2;
    localparam int STAT_FLOW_BIT = 3;
    localparam int SYNC_STAGES = 2;
endpackage : gdh_pkg

// ### gdh_sync2.sv
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to i_clk
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module gdh_sync2 (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_d,
    output logic o_q
);
    logic meta;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule : gdh_sync2

// ### gdh_hold_stage.sv
// Purpose: delays a word by none, half or one clock
// Assumes: i_d comes from a rising-edge register
// Notes: half uses the falling edge, one an extra rising stage
`timescale 1ns/1ps
module gdh_hold_stage #(
    parameter int W = 17
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    input wire logic [1:0] i_sel,
    output logic [W-1:0] o_q
);
    logic [W-1:0] q_half;
    logic [W-1:0] q_one;

    // half hold: retimed on the opposite edge
    always_ff @(negedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_half <= '0;
        end else begin
            q_half <= i_d;
        end
    end

    // one hold: a single extra register stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_one <= '0;
        end else begin
            q_one <= i_d;
        end
    end

    always_comb begin
        unique case (i_sel)
            gdh_pkg::HOLD_HALF: o_q = q_half;
            gdh_pkg::HOLD_ONE: o_q = q_one;
            default: o_q = i_d;
        endcase
    end
endmodule : gdh_hold_stage

// ### gdh_hold_top.sv
// Purpose: data hold control for the waveform engine data bus
// Assumes: engine signals share I_REF_CLK; ready strobe is a pin
// Notes: hold applies to data and output enable alike
`timescale 1ns/1ps
module gdh_hold_top (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic [15:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    input wire logic [15:0] I_ENG_DATA,
    input wire logic I_ENG_DRIVE,
    input wire logic I_ENG_FLOW,
    input wire logic I_FLOW_SLAVE,
    input wire logic I_STROBE_EDGE,
    input wire logic I_RDY_STROBE,
    output logic [15:0] O_FD_OUT,
    output logic O_FD_OE,
    output logic O_CTL_STROBE,
    output logic O_LAUNCH
);
    logic [1:0] hold_sel;
    logic [15:0] base_data;
    logic base_oe;
    logic rdy_s;
    logic rdy_prev;
    logic strobe;
    logic master_flow;
    logic slave_flow;
    logic master_act;
    logic slave_act;
    logic launch;
    logic [16:0] held;
    logic wr_hold;
    logic [7:0] next_rdata;

    assign master_flow = I_ENG_FLOW && !I_FLOW_SLAVE;
    assign slave_flow = I_ENG_FLOW && I_FLOW_SLAVE;
    assign wr_hold = I_REG_WR && (I_REG_ADDR == gdh_pkg::HOLD_AMOUNT_OFS);

    // register write: reserved code is not taken
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            hold_sel <= gdh_pkg::HOLD_RESET;
        end else if (wr_hold && I_REG_WDATA[1:0] != gdh_pkg::HOLD_RSVD) begin
            hold_sel <= I_REG_WDATA[1:0];
        end
    end

    always_comb begin
        next_rdata = gdh_pkg::UNMAPPED_RDATA;
        if (I_REG_ADDR == gdh_pkg::HOLD_AMOUNT_OFS) begin
            next_rdata[gdh_pkg::HOLD_FIELD_LSB +: gdh_pkg::HOLD_FIELD_W] =
                hold_sel;
        end else if (I_REG_ADDR == gdh_pkg::HOLD_STATUS_OFS) begin
            next_rdata[gdh_pkg::STAT_OE_BIT] = O_FD_OE;
            next_rdata[gdh_pkg::STAT_RDY_BIT] = rdy_s;
            next_rdata[gdh_pkg::STAT_STB_BIT] = strobe;
            next_rdata[gdh_pkg::STAT_FLOW_BIT] = I_ENG_FLOW;
        end
    end

    // read data valid in the cycle after the read strobe only
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= gdh_pkg::HOLD_AMOUNT_RESET;
        end else if (I_REG_RD) begin
            O_REG_RDATA <= next_rdata;
        end else begin
            O_REG_RDATA <= gdh_pkg::UNMAPPED_RDATA;
        end
    end

    gdh_sync2 u_rdy_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_d(I_RDY_STROBE),
        .o_q(rdy_s)
    );

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdy_prev <= 1'b0;
        end else begin
            rdy_prev <= rdy_s;
        end
    end

    // slave: activating edge seen after synchronisation
    assign slave_act = slave_flow &&
        (I_STROBE_EDGE ? (rdy_prev && !rdy_s) : (rdy_s && !rdy_prev));
    // master: strobe sits at idle level, next edge is the activating one
    assign master_act = master_flow && (strobe == I_STROBE_EDGE);
    assign launch = master_act || slave_act;

    // master strobe on the control output pin
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            strobe <= 1'b0;
        end else if (master_flow) begin
            strobe <= !strobe;
        end else begin
            strobe <= I_STROBE_EDGE;
        end
    end

    // unheld presentation of data and enable
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            base_data <= '0;
        end else if (!I_ENG_FLOW || launch) begin
            base_data <= I_ENG_DATA;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            base_oe <= 1'b0;
        end else begin
            base_oe <= I_ENG_DRIVE;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_LAUNCH <= 1'b0;
        end else begin
            O_LAUNCH <= launch;
        end
    end

    assign O_CTL_STROBE = strobe;

    // one hold path for every state, data and enable together
    gdh_hold_stage #(
        .W(17)
    ) u_hold (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_d({base_oe, base_data}),
        .i_sel(hold_sel),
        .o_q(held)
    );

    assign O_FD_OUT = held[15:0];
    assign O_FD_OE = held[16];

    sequence write_legal_s;
        wr_hold && I_REG_WDATA[1:0] != gdh_pkg::HOLD_RSVD;
    endsequence

    sequence steady_one_s;
        hold_sel == gdh_pkg::HOLD_ONE ##1 hold_sel == gdh_pkg::HOLD_ONE;
    endsequence

    sequence half_steady_s;
        hold_sel == gdh_pkg::HOLD_HALF ##1 hold_sel == gdh_pkg::HOLD_HALF;
    endsequence

    sequence status_read_s;
        I_REG_RD && I_REG_ADDR == gdh_pkg::HOLD_STATUS_OFS;
    endsequence

    field_write_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        write_legal_s |=> hold_sel == $past(I_REG_WDATA[1:0]))
        else $error("hold field did not take a legal write");

    reserved_code_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        wr_hold && I_REG_WDATA[1:0] == gdh_pkg::HOLD_RSVD
        |=> $stable(hold_sel))
        else $error("reserved hold code changed the field");

    no_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        hold_sel == gdh_pkg::HOLD_NONE
        |-> O_FD_OUT == base_data && O_FD_OE == base_oe)
        else $error("no-hold output differs from unheld data");

    one_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        steady_one_s |-> O_FD_OUT == $past(base_data))
        else $error("one-clock hold data is not one stage late");

    oe_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        steady_one_s |-> O_FD_OE == $past(base_oe))
        else $error("enable not held like the data");

    nonflow_data_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        !I_ENG_FLOW |=> base_data == $past(I_ENG_DATA))
        else $error("non-flow data not presented");

    master_edge_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        master_act |=> strobe != $past(I_STROBE_EDGE)
        && base_data == $past(I_ENG_DATA))
        else $error("master data not launched at activating edge");

    master_toggle_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        master_flow [*2] |-> strobe != $past(strobe))
        else $error("master strobe did not toggle");

    slave_launch_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        slave_act |=> O_LAUNCH && base_data == $past(I_ENG_DATA))
        else $error("slave data not launched on strobe");

    slave_sync_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        slave_act |-> rdy_s != $past(rdy_s))
        else $error("slave launch without synchronised edge");

    hold_read_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        I_REG_RD && I_REG_ADDR == gdh_pkg::HOLD_AMOUNT_OFS
        |=> O_REG_RDATA == {6'h00, $past(hold_sel)})
        else $error("hold register read back wrong");

    half_hold_a: assert property (
        @(negedge I_REF_CLK) disable iff (!I_RST_N)
        half_steady_s |-> O_FD_OUT == $past(base_data))
        else $error("half-clock hold data not retimed on falling edge");

    half_oe_a: assert property (
        @(negedge I_REF_CLK) disable iff (!I_RST_N)
        half_steady_s |-> O_FD_OE == $past(base_oe))
        else $error("half-clock enable not held like the data");

    rsvd_never_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        hold_sel != gdh_pkg::HOLD_RSVD)
        else $error("hold field holds the reserved code");

    write_other_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        I_REG_WR && I_REG_ADDR != gdh_pkg::HOLD_AMOUNT_OFS |=> $stable(hold_sel))
        else $error("write to another address changed the field");

    rdata_idle_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        !I_REG_RD |=> O_REG_RDATA == gdh_pkg::UNMAPPED_RDATA)
        else $error("read data not idle without a read");

    unmapped_read_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        I_REG_RD && I_REG_ADDR != gdh_pkg::HOLD_AMOUNT_OFS
        && I_REG_ADDR != gdh_pkg::HOLD_STATUS_OFS
        |=> O_REG_RDATA == gdh_pkg::UNMAPPED_RDATA)
        else $error("unmapped read returned data");

    status_flow_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        status_read_s |=> O_REG_RDATA[7:3] == {4'h0, $past(I_ENG_FLOW)})
        else $error("status flow bit read back wrong");

    status_oe_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        status_read_s |=> O_REG_RDATA[0] == $past(O_FD_OE))
        else $error("status enable bit read back wrong");

    status_rdy_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        status_read_s |=> O_REG_RDATA[1] == $past(rdy_s))
        else $error("status ready bit read back wrong");

    status_stb_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        status_read_s |=> O_REG_RDATA[2] == $past(strobe))
        else $error("status strobe bit read back wrong");

    master_keep_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        master_flow && !master_act |=> $stable(base_data))
        else $error("master data reloaded without activating edge");

    slave_keep_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        slave_flow && !slave_act |=> $stable(base_data))
        else $error("slave data reloaded without strobe");

    oe_base_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        I_RST_N |=> base_oe == $past(I_ENG_DRIVE))
        else $error("unheld enable does not follow the engine");

    launch_pulse_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        launch |=> O_LAUNCH)
        else $error("launch not reported");

    launch_quiet_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        !launch |=> !O_LAUNCH)
        else $error("launch reported without a launch");

    master_gap_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        master_act ##1 master_flow && $stable(I_STROBE_EDGE) |-> !master_act)
        else $error("master launched on two cycles in a row");

    master_idle_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        !master_flow |=> strobe == $past(I_STROBE_EDGE))
        else $error("strobe not at idle level outside master flow");

    nonflow_quiet_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        !I_ENG_FLOW |-> !launch)
        else $error("launch outside a flow state");

    slave_latency_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        slave_act |-> $past(I_RDY_STROBE, 2) != $past(I_RDY_STROBE, 3))
        else $error("slave launch not two clocks after pin edge");

    slave_rise_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        slave_act && !I_STROBE_EDGE |-> rdy_s && !rdy_prev)
        else $error("slave launch without rising strobe");

    slave_fall_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        slave_act && I_STROBE_EDGE |-> !rdy_s && rdy_prev)
        else $error("slave launch without falling strobe");

    release_oe_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        steady_one_s ##0 $fell(base_oe) |-> O_FD_OE)
        else $error("enable dropped before the hold ended");

    release_data_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        steady_one_s ##0 $fell(base_oe) |-> O_FD_OUT == $past(base_data))
        else $error("data not kept through the hold at release");

    launch_flow_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        O_LAUNCH |-> $past(I_ENG_FLOW))
        else $error("launch reported outside a flow state");
endmodule : gdh_hold_top

// ### gdh_partner.sv
// Purpose: far-side bus device issuing the ready strobe
// Assumes: strobe idles low, rising edge activates
// Notes: held three clocks so the synchroniser sees it
`timescale 1ns/1ps
module gdh_partner (
    input wire logic i_clk,
    output logic o_rdy
);
    initial o_rdy = 1'b0;
    // one master strobe toward the block in slave flow
    task automatic strobe;
        o_rdy <= 1'b1;
        repeat (3) @(posedge i_clk);
        o_rdy <= 1'b0;
    endtask : strobe
endmodule : gdh_partner

// ### gdh_hold_top_bench.sv
// Purpose: self-checking bench for the bus data hold block
// Assumes: 10 MHz clock, read data one cycle after the read strobe
// Notes: slave flow strobes come from gdh_partner
`timescale 1ns/1ps
module gdh_hold_top_bench;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic drive = 1'b0, flow = 1'b0, slv = 1'b0, edg = 1'b0;
    logic [15:0] addr = 16'h0000, edata = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata;
    logic [15:0] fd, exp, prev;
    logic oe, ctl, launch, rdy;
    int miscompares = 0;
    int n_tests = 0;
    initial forever #50 clk = ~clk;
    gdh_hold_top dut_u (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
        .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_ENG_DATA(edata),
        .I_ENG_DRIVE(drive), .I_ENG_FLOW(flow), .I_FLOW_SLAVE(slv),
        .I_STROBE_EDGE(edg), .I_RDY_STROBE(rdy), .O_FD_OUT(fd),
        .O_FD_OE(oe), .O_CTL_STROBE(ctl), .O_LAUNCH(launch));
    gdh_partner partner_u (.i_clk(clk), .o_rdy(rdy));
    // engine word changes every clock while in a flow state
    always @(posedge clk) begin
        if (flow) begin
            edata <= edata + 16'h0001;
        end
    end
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr_reg(input logic [7:0] d);
        addr <= gdh_pkg::HOLD_AMOUNT_OFS;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rchk(input logic [15:0] a, input logic [7:0] want);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #10;
        check("register", {8'h00, rdata}, {8'h00, want});
        @(posedge clk);
    endtask : rchk
    // t0 just after the load edge, t1 after the falling edge, t2 next edge
    task automatic phased(input int s, input logic [15:0] old,
        input logic [15:0] nw, input logic eo, input logic en);
        for (int t = 0; t < 3; t++) begin
            if (t == 1) begin
                #50;
            end else if (t == 2) begin
                @(posedge clk);
                #10;
            end
            check("bus data", fd, (t >= s) ? nw : old);
            check("bus enable", 16'(oe), 16'((t >= s) ? en : eo));
        end
    endtask : phased
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(gdh_pkg::HOLD_AMOUNT_OFS, 8'h00);
        rchk(16'hE60E, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'hFC | 8'(c));
            rchk(gdh_pkg::HOLD_AMOUNT_OFS, (c == 3) ? 8'h02 : 8'(c));
        end
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            wr_reg(8'(s));
            edata <= 16'h0000;
            repeat (3) @(posedge clk);
            edata <= 16'hA5C3;
            drive <= 1'b1;
            @(posedge clk);
            #10;
            phased(s, 16'h0000, 16'hA5C3, 1'b0, 1'b1);
            @(posedge clk);
            drive <= 1'b0;
            @(posedge clk);
            #10;
            phased(s, 16'hA5C3, 16'hA5C3, 1'b1, 1'b0);
        end
        @(posedge clk);
        flow <= 1'b1;
        drive <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 3; s++) begin
                @(posedge clk);
                edg <= e[0];
                wr_reg(8'(s));
                repeat (4) @(posedge clk);
                do begin
                    @(posedge clk);
                    #10;
                end while (ctl !== ~e[0]);
                exp = edata - 16'h0001;
                check("launch", 16'(launch), 16'h0001);
                phased(s, exp - 16'h0002, exp, 1'b1, 1'b1);
                check("strobe", 16'(ctl), 16'(e[0]));
                check("launch", 16'(launch), 16'h0000);
            end
        end
        @(posedge clk);
        slv <= 1'b1;
        edg <= 1'b0;
        @(posedge clk);
        rchk(gdh_pkg::HOLD_STATUS_OFS, 8'h09);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            wr_reg(8'((i + 2) % 3));
            repeat (4) @(posedge clk);
            fork
                partner_u.strobe();
            join_none
            repeat (2) @(posedge clk);
            #10;
            check("launch", 16'(launch), 16'h0000);
            @(posedge clk);
            #10;
            exp = edata - 16'h0001;
            check("launch", 16'(launch), 16'h0001);
            if (i > 0) begin
                phased((i + 2) % 3, prev, exp, 1'b1, 1'b1);
            end
            prev = exp;
        end
        tally_and_finish();
    end
    initial begin
        #2000000;
        miscompares++;
        tally_and_finish();
    end
endmodule : gdh_hold_top_bench
